// >>> rtl/swt_pkg.sv
// Package of constants and types for the BCD stopwatch timer
package swt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_PRIORITY   = 16'hFF20;
  localparam logic [15:0] IDX_ENABLE     = 16'hFF22;
  localparam logic [15:0] IDX_FLAGS      = 16'hFF24;
  localparam logic [15:0] IDX_MODE       = 16'hFF42;
  localparam logic [15:0] IDX_COUNT      = 16'hFF43;
  localparam logic [15:0] IDX_INT_STATUS = 16'hFF44;
  localparam logic [15:0] IDX_INT_MASK   = 16'hFF45;
  // Field positions
  localparam int BIT_RUN      = 0;
  localparam int BIT_CLEAR    = 1;
  localparam int BIT_EV_SEC   = 4;
  localparam int BIT_EV_TENTH = 5;
  localparam int BIT_EV_HUND  = 6;
  localparam int BIT_PRIO_LO  = 2;
  localparam int BIT_PRIO_HI  = 3;
  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_EV    = 3'h0;
  localparam logic [1:0] RST_PRIO  = 2'h0;
  // Vector table offsets
  localparam logic [7:0] VEC_HUND  = 8'h16;
  localparam logic [7:0] VEC_TENTH = 8'h18;
  localparam logic [7:0] VEC_SEC   = 8'h1A;
  localparam logic [7:0] VEC_NONE  = 8'h00;
  // Timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_NS = 3906250;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [8:0] STEP_ADD  = 9'h064;
  localparam logic [8:0] STEP_WRAP = 9'h100;
  localparam logic [3:0] BCD_MAX   = 4'h9;
  // Event group: hund = bit 2, tenth = bit 1, sec = bit 0
  typedef struct packed {
    logic hund;
    logic tenth;
    logic sec;
  } swt_evt_t;
endpackage : swt_pkg

// >>> rtl/swt_top.sv
// BCD stopwatch timer with APB register slave and interrupt logic
// Behaviour
// [R01] Run bit runs or halts counter
// [R02] Writing clear bit zeroes the count
// [R03] Count byte holds tenths and hundredths BCD
// [R04] Stop takes effect after one aligned count
// [R05] Separate enables for three events, reset off
// [R06] Event flags set on each event
// [R07] Flags set always; request needs enable
// [R08] Write one clears flag, zero keeps
// [R09] Two-bit priority field, resets to zero
// [R10] Distinct vector offsets per event
// [R11] Hundredths steps, carries raise tenth, second
//
// Added by the designer: the APB slave port.
module swt_top
  import swt_pkg::*;
#(
  parameter int TICK_DIV = swt_pkg::TICK_CYCLES,
  parameter int AW       = 18
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [AW-1:0]    paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  irq,
  output swt_pkg::swt_evt_t     sw_req,
  output logic      [1:0]       sw_priority,
  output logic      [7:0]       sw_vector
);
  import swt_pkg::*;

  localparam int TW = $clog2(TICK_DIV + 1);

  logic [TW-1:0] div_r,     div_nxt;
  logic          tick_r,    tick_nxt;
  logic [7:0]    acc_r,     acc_nxt;
  logic [3:0]    tenths_r,  tenths_nxt;
  logic [3:0]    hunds_r,   hunds_nxt;
  logic          run_r,     run_nxt;
  logic          active_r,  active_nxt;
  swt_evt_t      evt_r,     evt_nxt;
  swt_evt_t      flags_r,   flags_nxt;
  swt_evt_t      en_r,      en_nxt;
  swt_evt_t      stat_r,    stat_nxt;
  swt_evt_t      mask_r,    mask_nxt;
  logic [1:0]    prio_r,    prio_nxt;
  logic [31:0]   prdata_r,  prdata_nxt;
  logic          pready_r,  pready_nxt;
  logic          pslverr_r, pslverr_nxt;
  logic          irq_r,     irq_nxt;
  swt_evt_t      req_r,     req_nxt;
  logic [7:0]    vec_r,     vec_nxt;

  logic [15:0]   idx;
  logic          setup;
  logic          done;
  logic          wr;
  logic          rd;
  logic          wr_lane0;
  logic [7:0]    wbyte;
  logic          hit;
  logic [8:0]    acc_sum;
  logic          step;
  swt_evt_t      wr_evt;

  assign idx      = paddr[17:2];
  assign setup    = psel && !penable;
  assign done     = psel && penable && pready_r;
  assign wr       = done && pwrite;
  assign rd       = done && !pwrite;
  assign wr_lane0 = wr && pstrb[0];
  assign wbyte    = pwdata[7:0];
  assign wr_evt   = '{hund: wbyte[BIT_EV_HUND], tenth: wbyte[BIT_EV_TENTH], sec: wbyte[BIT_EV_SEC]};
  assign hit      = (idx == IDX_PRIORITY) || (idx == IDX_ENABLE) || (idx == IDX_FLAGS) ||
                    (idx == IDX_MODE) || (idx == IDX_COUNT) || (idx == IDX_INT_STATUS) ||
                    (idx == IDX_INT_MASK);
  assign acc_sum  = {1'b0, acc_r} + STEP_ADD;

  // 256 Hz base tick from a divider
  always_comb begin
    div_nxt  = div_r + 1'b1;
    tick_nxt = 1'b0;
    if (div_r == TW'(TICK_DIV - 1)) begin
      div_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Counter: a run bit cleared keeps it going until the next base tick, where it takes one last count
  always_comb begin
    step       = 1'b0;
    acc_nxt    = acc_r;
    active_nxt = active_r;
    tenths_nxt = tenths_r;
    hunds_nxt  = hunds_r;
    evt_nxt    = '0;
    if (run_r) begin
      active_nxt = 1'b1; // R01
    end
    if (tick_r && active_r) begin
      if (!run_r) begin
        step       = 1'b1; // R04
        active_nxt = 1'b0; // R04
        acc_nxt    = '0;
      end else if (acc_sum >= STEP_WRAP) begin
        step    = 1'b1; // R11
        acc_nxt = 8'(acc_sum - STEP_WRAP);
      end else begin
        acc_nxt = acc_sum[7:0];
      end
    end
    if (step) begin
      evt_nxt.hund = 1'b1; // R11
      if (hunds_r == BCD_MAX) begin
        hunds_nxt     = 4'h0;
        evt_nxt.tenth = 1'b1; // R11
        if (tenths_r == BCD_MAX) begin
          tenths_nxt  = 4'h0;
          evt_nxt.sec = 1'b1; // R11
        end else begin
          tenths_nxt = tenths_r + 4'h1;
        end
      end else begin
        hunds_nxt = hunds_r + 4'h1;
      end
    end
    // Clear outranks a step in the same cycle and drops the partial hundredth
    if (wr_lane0 && idx == IDX_MODE && wbyte[BIT_CLEAR]) begin
      tenths_nxt = 4'h0; // R02
      hunds_nxt  = 4'h0; // R02
      acc_nxt    = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r    <= '0;
      active_r <= 1'b0;
      tenths_r <= 4'h0;
      hunds_r  <= 4'h0;
      evt_r    <= RST_EV;
    end else begin
      acc_r    <= acc_nxt;
      active_r <= active_nxt;
      tenths_r <= tenths_nxt;
      hunds_r  <= hunds_nxt;
      evt_r    <= evt_nxt;
    end
  end

  // Registers, flags and interrupt outputs; hardware set beats software clear
  always_comb begin
    run_nxt     = run_r;
    en_nxt      = en_r;
    mask_nxt    = mask_r;
    prio_nxt    = prio_r;
    flags_nxt   = flags_r;
    stat_nxt    = stat_r;
    prdata_nxt  = prdata_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (wr_lane0) begin
      case (idx)
        IDX_MODE:     run_nxt   = wbyte[BIT_RUN]; // R01
        IDX_ENABLE:   en_nxt    = wr_evt; // R05
        IDX_INT_MASK: mask_nxt  = wr_evt;
        IDX_PRIORITY: prio_nxt  = wbyte[BIT_PRIO_HI:BIT_PRIO_LO]; // R09
        IDX_FLAGS:    flags_nxt = flags_r & ~wr_evt; // R08
        default:      run_nxt   = run_r;
      endcase
    end
    if (rd && idx == IDX_INT_STATUS) begin
      stat_nxt = '0;
    end
    flags_nxt = flags_nxt | evt_r; // R06 R07
    stat_nxt  = stat_nxt | evt_r;
    // Status read shows events landing now, else the read's clear would lose them
    if (setup) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !hit;
      prdata_nxt  = '0;
      case (idx)
        IDX_MODE:       prdata_nxt[BIT_RUN] = run_r;
        IDX_COUNT:      prdata_nxt[7:0] = {tenths_r, hunds_r}; // R03
        IDX_PRIORITY:   prdata_nxt[BIT_PRIO_HI:BIT_PRIO_LO] = prio_r;
        IDX_ENABLE:     prdata_nxt[BIT_EV_HUND:BIT_EV_SEC] = en_r;
        IDX_FLAGS:      prdata_nxt[BIT_EV_HUND:BIT_EV_SEC] = flags_r;
        IDX_INT_STATUS: prdata_nxt[BIT_EV_HUND:BIT_EV_SEC] = stat_r | evt_r;
        IDX_INT_MASK:   prdata_nxt[BIT_EV_HUND:BIT_EV_SEC] = mask_r;
        default:        prdata_nxt = '0;
      endcase
    end
    req_nxt = flags_r & en_r; // R07
    irq_nxt = |(stat_r & mask_r);
    // Hundredths outranks tenths outranks seconds when several are pending
    if (req_nxt.hund) begin
      vec_nxt = VEC_HUND; // R10
    end else if (req_nxt.tenth) begin
      vec_nxt = VEC_TENTH; // R10
    end else if (req_nxt.sec) begin
      vec_nxt = VEC_SEC; // R10
    end else begin
      vec_nxt = VEC_NONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r     <= 1'b0;
      en_r      <= RST_EV;
      mask_r    <= RST_EV;
      prio_r    <= RST_PRIO;
      flags_r   <= RST_EV;
      stat_r    <= RST_EV;
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      req_r     <= RST_EV;
      irq_r     <= 1'b0;
      vec_r     <= VEC_NONE;
    end else begin
      run_r     <= run_nxt;
      en_r      <= en_nxt;
      mask_r    <= mask_nxt;
      prio_r    <= prio_nxt;
      flags_r   <= flags_nxt;
      stat_r    <= stat_nxt;
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      req_r     <= req_nxt;
      irq_r     <= irq_nxt;
      vec_r     <= vec_nxt;
    end
  end

  assign prdata      = prdata_r;
  assign pready      = pready_r;
  assign pslverr     = pslverr_r;
  assign irq         = irq_r;
  assign sw_req      = req_r;
  assign sw_priority = prio_r;
  assign sw_vector   = vec_r;

  // Cycles spent stopping; a full base tick is far beyond any delay range in a property
  logic [TW:0]   stop_wait_r, stop_wait_nxt;

  always_comb begin
    stop_wait_nxt = stop_wait_r + 1'b1;
    if (run_r || !active_r) begin
      stop_wait_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_wait_r <= '0;
    end else begin
      stop_wait_r <= stop_wait_nxt;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  run_bit_a: assert property (wr_lane0 && idx == IDX_MODE |=> run_r == $past(wbyte[BIT_RUN])) // R01
    else $error("run bit did not follow write");
  halt_hold_a: assert property (!active_r && !run_r && !wr |=> {tenths_r, hunds_r} == $past({tenths_r, hunds_r})) // R01
    else $error("halted counter moved");
  clear_count_a: assert property (wr_lane0 && idx == IDX_MODE && wbyte[BIT_CLEAR] |=> tenths_r == 4'h0 && hunds_r == 4'h0) // R02
    else $error("clear did not zero count");
  bcd_range_a: assert property (tenths_r <= BCD_MAX && hunds_r <= BCD_MAX) // R03
    else $error("count digit not BCD");
  stop_aligned_a: assert property ($fell(active_r) |-> $past(tick_r) && $past(evt_nxt.hund)) // R04
    else $error("stop not aligned to a final count");
  enable_write_a: assert property (wr_lane0 && idx == IDX_ENABLE |=> en_r == $past(wr_evt)) // R05
    else $error("enable write lost");
  flag_set_a: assert property (evt_r.hund |=> flags_r.hund && stat_r.hund) // R06
    else $error("event flag not set");
  req_gate_a: assert property (req_r.tenth |-> $past(flags_r.tenth) && $past(en_r.tenth)) // R07
    else $error("request without flag and enable");
  w1c_keep_a: assert property (wr_lane0 && idx == IDX_FLAGS && !wr_evt.sec && flags_r.sec |=> flags_r.sec) // R08
    else $error("zero write cleared flag");
  prio_write_a: assert property (wr_lane0 && idx == IDX_PRIORITY |=> ##1 sw_priority == $past(wbyte[3:2], 2)) // R09
    else $error("priority field wrong");
  vector_a: assert property (sw_req.hund |-> sw_vector == VEC_HUND) // R10
    else $error("vector offset wrong");
  carry_a: assert property (evt_r.sec |-> evt_r.tenth && evt_r.hund && tenths_r == 4'h0) // R11
    else $error("second event without carry");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");

  // Checks on stopping, run, enables, flags, requests, priority, vectors, carries, interrupt and the bus answer
  stop_bound_a: assert property (stop_wait_r <= (TW + 1)'(TICK_DIV)) // R04
    else $error("stop took longer than one base tick");
  run_active_a: assert property (run_r |=> active_r) // R01
    else $error("running counter not active");
  mode_read_a: assert property (pready && !pwrite && idx == IDX_MODE |-> prdata[BIT_CLEAR] == 1'b0) // R02
    else $error("clear bit read back as one");
  enable_hold_a: assert property (!(wr_lane0 && idx == IDX_ENABLE) |=> $stable(en_r)) // R05
    else $error("enable changed without write");
  flag_all_a: assert property (evt_r != '0 |=> (flags_r & $past(evt_r)) == $past(evt_r)) // R06
    else $error("event flag missed");
  req_enable_a: assert property (!en_r.sec |=> !sw_req.sec) // R07
    else $error("request without enable");
  w1c_clear_a: assert property (wr_lane0 && idx == IDX_FLAGS && wr_evt.sec && !evt_r.sec |=> !flags_r.sec) // R08
    else $error("one write kept flag");
  prio_hold_a: assert property (!(wr_lane0 && idx == IDX_PRIORITY) |=> $stable(sw_priority)) // R09
    else $error("priority changed without write");
  vector_tenth_a: assert property (sw_req.tenth && !sw_req.hund |-> sw_vector == VEC_TENTH) // R10
    else $error("tenth vector wrong");
  vector_sec_a: assert property (sw_req.sec && !sw_req.tenth && !sw_req.hund |-> sw_vector == VEC_SEC) // R10
    else $error("second vector wrong");
  tenth_carry_a: assert property (evt_r.tenth |-> evt_r.hund && hunds_r == 4'h0) // R11
    else $error("tenth event without carry");
  irq_set_a: assert property ((stat_r & mask_r) != '0 |=> irq)
    else $error("irq missing for unmasked status");
  irq_clear_a: assert property ((stat_r & mask_r) == '0 |=> !irq)
    else $error("irq without unmasked status");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("pslverr outside answer");

  run_cover_c: cover property (run_r && evt_r.sec);
  stop_cover_c: cover property ($fell(active_r) && stop_wait_r != '0);
  stat_cover_c: cover property (rd && idx == IDX_INT_STATUS && stat_r != '0);
  irq_cover_c: cover property (irq && sw_req.hund);
  clear_cover_c: cover property (wr_lane0 && idx == IDX_FLAGS && evt_r.tenth);
endmodule : swt_top

// >>> tb/swt_top_bench.sv
// Self-checking bench for the BCD stopwatch timer
module swt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import swt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, perr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd, cnt;
  logic [3:0]  pstrb;
  swt_evt_t    sw_req;
  logic [1:0]  sw_priority;
  logic [7:0]  sw_vector;
  int          err_total, checked, cycles;

  // Short tick keeps a full second near a thousand cycles
  swt_top #(.TICK_DIV(4)) i_swt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sw_req(sw_req), .sw_priority(sw_priority), .sw_vector(sw_vector));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // One transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string what, input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h000000, exp}, rd);
  endtask : rdc

  task automatic t_reset();
    rdc("prio", IDX_PRIORITY, 8'h00);
    rdc("enable", IDX_ENABLE, 8'h00);
    rdc("flags", IDX_FLAGS, 8'h00);
    rdc("mode", IDX_MODE, 8'h00);
    rdc("count", IDX_COUNT, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_prio();
    apb(1'b1, IDX_PRIORITY, 8'hFF);
    rdc("prio", IDX_PRIORITY, 8'h0C);
    cyc(2);
    chk("sw_priority", 32'h3, {30'h0, sw_priority});
    apb(1'b1, IDX_PRIORITY, 8'h08);
    cyc(2);
    chk("sw_priority", 32'h2, {30'h0, sw_priority});
    pstrb <= 4'hE;
    apb(1'b1, IDX_PRIORITY, 8'h0C);
    pstrb <= 4'hF;
    rdc("prio_strb", IDX_PRIORITY, 8'h08);
    $display("test priority done");
  endtask : t_prio

  // Past one second so all three events fire with enables off
  task automatic t_run();
    apb(1'b1, IDX_MODE, 8'h03);
    rdc("mode_run", IDX_MODE, 8'h01);
    cyc(1200);
    apb(1'b1, IDX_MODE, 8'h00);
    cyc(20);
    rdc("flags", IDX_FLAGS, 8'h70);
    chk("sw_req", 32'h0, {29'h0, sw_req});
    apb(1'b0, IDX_COUNT, 8'h00);
    cnt = rd;
    chk("count_bcd", 32'h1, {31'h0, cnt[7:4] <= 4'h9 && cnt[3:0] <= 4'h9});
    cyc(50);
    rdc("mode", IDX_MODE, 8'h00);
    apb(1'b1, IDX_COUNT, 8'hFF);
    rdc("count_held", IDX_COUNT, cnt[7:0]);
    apb(1'b0, 16'h0000, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, perr});
    chk("unmapped_data", 32'h0, rd);
    $display("test run done");
  endtask : t_run

  task automatic t_irq();
    apb(1'b1, IDX_INT_MASK, 8'h00);
    cyc(3);
    chk("irq_masked", 32'h0, {31'h0, irq});
    apb(1'b1, IDX_INT_MASK, 8'h10);
    cyc(3);
    chk("irq_on", 32'h1, {31'h0, irq});
    rdc("mask", IDX_INT_MASK, 8'h10);
    rdc("status", IDX_INT_STATUS, 8'h70);
    cyc(3);
    chk("irq_off", 32'h0, {31'h0, irq});
    rdc("status_clr", IDX_INT_STATUS, 8'h00);
    $display("test interrupt done");
  endtask : t_irq

  // Brief run is shorter than one step, so only the stop step shows
  task automatic t_stop();
    apb(1'b1, IDX_MODE, 8'h02);
    rdc("count_clr", IDX_COUNT, 8'h00);
    apb(1'b1, IDX_MODE, 8'h01);
    apb(1'b1, IDX_MODE, 8'h00);
    cyc(20);
    rdc("count_stop", IDX_COUNT, 8'h01);
    apb(1'b1, IDX_MODE, 8'h01);
    apb(1'b1, IDX_MODE, 8'h00);
    cyc(20);
    rdc("count_stop2", IDX_COUNT, 8'h02);
    apb(1'b1, IDX_MODE, 8'h00);
    rdc("count_noclr", IDX_COUNT, 8'h02);
    $display("test stop done");
  endtask : t_stop

  task automatic fstep(input logic [7:0] en, w1c, fl, input logic [2:0] req, input logic [7:0] vec);
    apb(1'b1, IDX_ENABLE, en);
    apb(1'b1, IDX_FLAGS, w1c);
    cyc(3);
    rdc("flags", IDX_FLAGS, fl);
    chk("sw_req", {29'h0, req}, {29'h0, sw_req});
    chk("sw_vector", {24'h0, vec}, {24'h0, sw_vector});
  endtask : fstep

  task automatic t_flags();
    fstep(8'h70, 8'h00, 8'h70, 3'h7, VEC_HUND);
    rdc("enable", IDX_ENABLE, 8'h70);
    fstep(8'h70, 8'h40, 8'h30, 3'h3, VEC_TENTH);
    fstep(8'h70, 8'h20, 8'h10, 3'h1, VEC_SEC);
    fstep(8'h00, 8'h00, 8'h10, 3'h0, VEC_NONE);
    fstep(8'h70, 8'h10, 8'h00, 3'h0, VEC_NONE);
    $display("test flags done");
  endtask : t_flags

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    pstrb   = 4'hF;
    err_total = 0;
    checked   = 0;
    cycles    = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prio();
    t_run();
    t_irq();
    t_stop();
    t_flags();
    finish_test();
  end
endmodule : swt_top_bench
